//--- rtl/sdl_consts.vh
/*
 * Constants for the serial converter load logic: widths, timing figures,
 * code points of the converter register.
 * Assumes inclusion by bare name from rtl/ design files.
 */
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH

`define SDL_DATA_W 12
`define SDL_CHAIN_LEN 12
`define SDL_CLK_NS 50
`define SDL_STROBE_MIN_NS 80
`define SDL_CLEAR_MIN_NS 80
`define SDL_DAC_RESET 12'h000
`define SDL_BIPOLAR_ZERO 12'h800
`define SDL_BUF_DEPTH 2
// pin idle levels {clear, load b, load a, data, d, c, b, a}
`define SDL_PIN_IDLE 8'hE4
// strobe idle levels {d, c, b, a}
`define SDL_STB_IDLE 4'h4
// strobes whose active edge is falling {d, c, b, a}
`define SDL_STB_FALL_ACT 4'h4

`endif

//--- rtl/sdl_load_logic.v
/*
 * Digital front end of a 12-bit serial-input multiplying converter:
 * strobe-clocked input shift register, daisy-chain output, transfer of
 * the input register to the converter register, asynchronous zeroing.
 * Assumes all strobes, data, loads and clear come from outside the clk
 * domain; each passes a two-flop synchroniser. clk must run well above
 * the strobe rate (each strobe phase lasts at least 1.6 clk periods).
 * Pins are expected at their idle levels when reset is released.
 * Clear acts through the synchroniser, so the converter register
 * zeros three clk edges after the pin falls rather than at once.
 * A load into a full code buffer is not stored; watch shift_ready.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sdl_consts.vh"

module sdl_load_logic #(
	parameter DATA_W = `SDL_DATA_W,
	parameter BUF_DEPTH = `SDL_BUF_DEPTH
) (
	input wire clk,
	input wire rst,
	input wire shift_strobe_a,
	input wire shift_strobe_b,
	input wire shift_strobe_c_inverted,
	input wire shift_strobe_d,
	input wire serial_data_in,
	input wire transfer_enable_a_n,
	input wire transfer_enable_b_n,
	input wire async_zero_n,
	input wire code_ready,
	output reg daisy_chain_out,
	output reg [DATA_W-1:0] dac_code,
	output reg [DATA_W-1:0] code_data,
	output reg code_valid,
	output reg bipolar_zero,
	output reg shift_ready
);
	// positions in the synchroniser vector
	localparam integer NPIN = 8;
	localparam integer NSTB = 4;
	localparam integer P_STB_A = 0;
	localparam integer P_STB_B = 1;
	localparam integer P_STB_C = 2;
	localparam integer P_STB_D = 3;
	localparam integer P_SDATA = 4;
	localparam integer P_LD_A = 5;
	localparam integer P_LD_B = 6;
	localparam integer P_ZERO = 7;
	localparam [NPIN-1:0] PIN_IDLE = `SDL_PIN_IDLE;
	localparam [NSTB-1:0] STB_IDLE = `SDL_STB_IDLE;
	localparam [NSTB-1:0] STB_FALL_ACT = `SDL_STB_FALL_ACT;

	wire [NPIN-1:0] pin_raw;
	reg [NPIN-1:0] pin_s1;
	reg [NPIN-1:0] pin_s2;

	assign pin_raw[P_STB_A] = shift_strobe_a;
	assign pin_raw[P_STB_B] = shift_strobe_b;
	assign pin_raw[P_STB_C] = shift_strobe_c_inverted;
	assign pin_raw[P_STB_D] = shift_strobe_d;
	assign pin_raw[P_SDATA] = serial_data_in;
	assign pin_raw[P_LD_A] = transfer_enable_a_n;
	assign pin_raw[P_LD_B] = transfer_enable_b_n;
	assign pin_raw[P_ZERO] = async_zero_n;

	// two-flop synchroniser: pin_s1 feeds pin_s2 and nothing else;
	// reset to the idle pin levels so release shows no false edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	wire [NSTB-1:0] stb_now;
	wire [NSTB-1:0] stb_en;
	wire [NSTB-1:0] stb_act;
	wire [NSTB-1:0] stb_fire;
	reg [NSTB-1:0] stb_prev;
	wire sdata;
	wire ld_a_n;
	wire ld_b_n;
	wire zero_n;

	assign stb_now[0] = pin_s2[P_STB_A];
	assign stb_now[1] = pin_s2[P_STB_B];
	assign stb_now[2] = pin_s2[P_STB_C];
	assign stb_now[3] = pin_s2[P_STB_D];
	assign sdata = pin_s2[P_SDATA];
	assign ld_a_n = pin_s2[P_LD_A];
	assign ld_b_n = pin_s2[P_LD_B];
	assign zero_n = pin_s2[P_ZERO];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stb_prev <= STB_IDLE;
		end else begin
			stb_prev <= stb_now;
		end
	end

	// per strobe: enabling level, active edge, edge taken; an edge
	// leaves its own strobe disabling, so only the other three count
	genvar gs;
	generate
		for (gs = 0; gs < NSTB; gs = gs + 1) begin : g_stb
			localparam [NSTB-1:0] SELF = {{(NSTB-1){1'h0}}, 1'h1} << gs;
			if (STB_FALL_ACT[gs]) begin : g_fall
				assign stb_en[gs] = stb_now[gs];
				assign stb_act[gs] = ~stb_now[gs] & stb_prev[gs];
			end else begin : g_rise
				assign stb_en[gs] = ~stb_now[gs];
				assign stb_act[gs] = stb_now[gs] & ~stb_prev[gs];
			end
			assign stb_fire[gs] = stb_act[gs] & (&(stb_en | SELF));
		end
	endgenerate

	// any disabling strobe besides the clocking one blocks the shift
	wire shift_evt;
	assign shift_evt = |stb_fire;

	// input register: one stage per bit, msb first, the oldest bit
	// leaving the top toward the chain output
	reg [DATA_W-1:0] in_reg;
	wire [DATA_W-1:0] next_in_reg;
	assign next_in_reg[0] = shift_evt ? sdata : in_reg[0];
	genvar gb;
	generate
		for (gb = 1; gb < DATA_W; gb = gb + 1) begin : g_bit
			assign next_in_reg[gb] = shift_evt ? in_reg[gb-1] : in_reg[gb];
		end
	endgenerate

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			in_reg <= {DATA_W{1'h0}};
		end else begin
			in_reg <= next_in_reg;
		end
	end

	// chain output: the bit leaving the msb end was shifted in twelve
	// bits ago, so a second device sees one longer register
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			daisy_chain_out <= 1'h0;
		end else if (shift_evt) begin
			daisy_chain_out <= in_reg[DATA_W-1];
		end
	end

	// converter register
	wire load_now;
	wire [DATA_W-1:0] load_src;
	wire code_is_mid;
	assign load_now = zero_n & ~ld_a_n & ~ld_b_n;
	// a bit taken in the same cycle is already part of the word
	assign load_src = next_in_reg;
	// straight and offset binary share one register; only the
	// mid code gets a flag of its own
	assign code_is_mid = (load_src == `SDL_BIPOLAR_ZERO);

	// clear goes through the synchroniser to keep one clock domain;
	// the shortest clear pulse still spans at least one clk edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dac_code <= `SDL_DAC_RESET;
		end else if (!zero_n) begin
			dac_code <= `SDL_DAC_RESET;
		end else if (load_now) begin
			dac_code <= load_src;
		end else begin
			dac_code <= dac_code;
		end
	end

	// flag follows the register: cleared with it, set by a load of the mid code and cleared by any other load
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bipolar_zero <= 1'h0;
		end else if (!zero_n) begin
			bipolar_zero <= 1'h0;
		end else if (load_now) begin
			bipolar_zero <= code_is_mid;
		end
	end

	// two-entry buffer of transferred codes toward the output stage
	reg [DATA_W-1:0] buf_mem [0:BUF_DEPTH-1];
	reg buf_wp;
	reg buf_rp;
	reg [1:0] buf_cnt;
	reg [1:0] next_buf_cnt;
	reg load_prev;
	wire load_evt;
	wire buf_full;
	wire buf_push;
	wire buf_pop;
	wire next_code_valid;
	// one entry per load, however long the load level stands;
	// a load into a full buffer is dropped, shift_ready warns ahead
	assign load_evt = load_now & ~load_prev;
	assign buf_full = (buf_cnt == 2'h2);
	assign buf_push = load_evt & ~buf_full;
	assign buf_pop = code_valid & code_ready;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			load_prev <= 1'h0;
		end else begin
			load_prev <= load_now;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_mem[0] <= {DATA_W{1'h0}};
			buf_mem[1] <= {DATA_W{1'h0}};
		end else if (buf_push) begin
			buf_mem[buf_wp] <= load_src;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_wp <= 1'h0;
			buf_rp <= 1'h0;
		end else begin
			if (buf_push) begin
				buf_wp <= ~buf_wp;
			end
			if (buf_pop) begin
				buf_rp <= ~buf_rp;
			end
		end
	end

	// occupancy after this edge
	always @* begin
		next_buf_cnt = buf_cnt;
		if (buf_push & ~buf_pop) begin
			next_buf_cnt = buf_cnt + 2'h1;
		end else if (buf_pop & ~buf_push) begin
			next_buf_cnt = buf_cnt - 2'h1;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_cnt <= 2'h0;
		end else begin
			buf_cnt <= next_buf_cnt;
		end
	end

	// the head is read one cycle after the write, so a word pushed
	// into an empty buffer shows valid only once it is stored
	assign next_code_valid = (buf_cnt != 2'h0) &
		~(buf_pop & (buf_cnt == 2'h1));

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			code_valid <= 1'h0;
		end else begin
			code_valid <= next_code_valid;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			code_data <= {DATA_W{1'h0}};
		end else if (buf_pop) begin
			code_data <= buf_mem[~buf_rp];
		end else begin
			code_data <= buf_mem[buf_rp];
		end
	end

	// tells the host that another transfer would find room
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_ready <= 1'h1;
		end else begin
			shift_ready <= ~buf_full;
		end
	end
endmodule
`default_nettype wire

//--- tb/sdl_host.sv
/* Host model: strobes, serial data, loads, clear.
 * Assumes the bench clock; pins move on falling edges. */
`timescale 1ns/1ns
`default_nettype none
module sdl_host (
	input wire logic clk,
	output logic shift_strobe_a = 0, shift_strobe_b = 0,
	output logic shift_strobe_c_inverted = 1, shift_strobe_d = 0,
	output logic serial_data_in = 0, async_zero_n = 1,
	output logic transfer_enable_a_n = 1, transfer_enable_b_n = 1
);
	logic blk = 0;
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	// 400 ns bit, each phase 200 ns
	task automatic put(input int s, input logic v);
		serial_data_in = v;
		shift_strobe_b = blk;
		wt(4);
		case (s)
			0: shift_strobe_a = 1;
			1: shift_strobe_b = 1;
			2: shift_strobe_c_inverted = 0;
			default: shift_strobe_d = 1;
		endcase
		wt(4);
		{shift_strobe_a, shift_strobe_d} = 0;
		shift_strobe_b = blk;
		shift_strobe_c_inverted = 1;
		serial_data_in = ~v;
	endtask
	// no gap after the last bit
	task automatic ld(input logic a, input logic b);
		{transfer_enable_a_n, transfer_enable_b_n} = {a, b};
		wt(4);
		{transfer_enable_a_n, transfer_enable_b_n} = 2'h3;
		wt(4);
	endtask
	task automatic clr;
		async_zero_n = 0;
		wt(4);
		async_zero_n = 1;
		wt(4);
	endtask
endmodule
`default_nettype wire

//--- tb/sdl_load_chk.sv
/* Port checker for the converter load logic.
 * Bound into every load logic instance below. */
`timescale 1ns/1ns
`default_nettype none
module sdl_load_chk #(parameter DATA_W = 12) (
	input wire logic clk, rst, async_zero_n, code_ready, code_valid,
	input wire logic transfer_enable_a_n, transfer_enable_b_n,
	input wire logic shift_strobe_a, shift_strobe_c_inverted,
	input wire logic daisy_chain_out, shift_ready,
	input wire logic [DATA_W-1:0] dac_code, code_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// loads or clear seen three edges before a change
	wire act = !async_zero_n || !(transfer_enable_a_n | transfer_enable_b_n);
	sequence s_nold;
		(transfer_enable_a_n || transfer_enable_b_n) && async_zero_n;
	endsequence
	property p_clr; !async_zero_n [*4] |-> dac_code == 0; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_hold; s_nold [*4] |=> $stable(dac_code); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_chg; $changed(dac_code) |-> $past(act, 3); endproperty
	a_chg: assert property (p_chg) else $error("load");
	property p_sa; shift_strobe_a [*5] |=> $stable(daisy_chain_out); endproperty
	a_sa: assert property (p_sa) else $error("strobe a");
	property p_sc;
		!shift_strobe_c_inverted [*5] |=> $stable(daisy_chain_out);
	endproperty
	a_sc: assert property (p_sc) else $error("strobe c");
	property p_vh;
		code_valid && !code_ready |=> code_valid && $stable(code_data);
	endproperty
	a_vh: assert property (p_vh) else $error("head");
	property p_full; !shift_ready |-> code_valid; endproperty
	a_full: assert property (p_full) else $error("full");
	property p_rr; $fell(rst) |-> shift_ready; endproperty
	a_rr: assert property (p_rr) else $error("ready");
endmodule
bind sdl_load_logic sdl_load_chk #(.DATA_W(DATA_W)) chk_u(.*);
`default_nettype wire

//--- tb/tb_sdl_load_logic.sv
/* Bench for the converter load logic with host model.
 * Assumes the checker is bound in by its own file. */
`timescale 1ns/1ns
`default_nettype none
module tb_sdl_load_logic;
	localparam logic [11:0] W1 = 12'hA5C, W2 = 12'h800, W3 = 12'h3C9;
	logic clk = 0, rst = 1, code_ready = 0;
	wire shift_strobe_a, shift_strobe_b, shift_strobe_c_inverted;
	wire shift_strobe_d, serial_data_in, async_zero_n;
	wire transfer_enable_a_n, transfer_enable_b_n;
	wire daisy_chain_out, code_valid, bipolar_zero, shift_ready;
	wire [11:0] dac_code, code_data;
	int err_count = 0, samples_checked = 0;
	sdl_host h(.*);
	sdl_load_logic dut_u(.*);
	initial forever #25 clk = ~clk;
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_chain;
		for (int i = 11; i >= 0; i--) h.put(i % 4, W1[i]);
		for (int i = 11; i >= 0; i--) begin
			h.put(i % 4, W2[i]);
			chk(daisy_chain_out, W1[i]);
		end
		h.ld(0, 0);
		chk(dac_code, W2);
		chk(bipolar_zero, 1);
		// raising b is itself a shift; the later a edge is blocked
		h.blk = 1;
		h.put(0, 1);
		chk(daisy_chain_out, W2[11]);
		h.put(3, 0);
		h.blk = 0;
		chk(daisy_chain_out, W2[11]);
	endtask
	task automatic t_hold;
		for (int i = 11; i >= 0; i--) h.put(0, W3[i]);
		h.ld(0, 1);
		h.ld(1, 0);
		chk(dac_code, W2);
		h.clr();
		chk(dac_code, 0);
		chk(bipolar_zero, 0);
		h.ld(0, 0);
		chk(dac_code, W3);
		chk(bipolar_zero, 0);
	endtask
	task automatic pop;
		code_ready = 1;
		h.wt(1);
		code_ready = 0;
		h.wt(2);
	endtask
	task automatic t_buf;
		chk(shift_ready, 0);
		chk(code_data, W2);
		pop();
		chk(code_data, W3);
		pop();
		chk(code_valid, 0);
		chk(shift_ready, 1);
	endtask
	initial begin
		h.wt(16);
		rst = 0;
		h.wt(4);
		chk(dac_code, 0);
		t_chain();
		t_hold();
		t_buf();
		complete_run();
	end
endmodule
`default_nettype wire
